// >>> hdl/qbsp_params.svh
// Purpose: Shared constants of the burst-of-four two-port SRAM link
// Assumes: One system clock; each input clock cycle is two system cycles
// Notes:   Timing counts are in system clock cycles
`ifndef QBSP_PARAMS_SVH
`define QBSP_PARAMS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define QBSP_WORD_W      18
`define QBSP_LANES       2
`define QBSP_ADDR_W      18
`define QBSP_BEATS       4

// ****************************************************************
// Pipeline positions, in system cycles after a start
// ****************************************************************
`define QBSP_WR_COMMIT   5
`define QBSP_RD_CAP_LO   3
`define QBSP_RD_CAP_HI   6

`endif

// >>> hdl/qbsp_pkg.sv
// Purpose: Types used by the controller end of the SRAM link
// Assumes: Nothing
// Notes:   Constants live in qbsp_params.svh
package qbsp_pkg;

   // ****************************************************************
   // Operation started on a positive input clock rise
   // ****************************************************************
   typedef enum logic [1:0] {
      QBSP_OP_NONE,
      QBSP_OP_READ,
      QBSP_OP_WRITE
   } qbsp_op_e;

endpackage

// >>> hdl/qbsp_if.sv
// Purpose: Pin bundle between memory controller and burst SRAM
// Assumes: k_rise high marks the positive input clock rise cycle
// Notes:   Read data is output only; rdata_oe stands for its driver
`timescale 1ns/1ns
`include "qbsp_params.svh"

interface qbsp_if #(
   parameter int WORD_W = `QBSP_WORD_W,
   parameter int LANES  = `QBSP_LANES,
   parameter int ADDR_W = `QBSP_ADDR_W
);
   logic              k_rise;
   logic              c_rise;
   logic              out_clk_tied_high;
   logic              read_port_select_n;
   logic              write_port_select_n;
   logic [ADDR_W-1:0] addr;
   logic [WORD_W-1:0] wdata;
   logic [LANES-1:0]  byte_write_select_n;
   logic [WORD_W-1:0] rdata;
   logic              rdata_oe;

   modport dev (
      input  k_rise,
      input  c_rise,
      input  out_clk_tied_high,
      input  read_port_select_n,
      input  write_port_select_n,
      input  addr,
      input  wdata,
      input  byte_write_select_n,
      output rdata,
      output rdata_oe
   );

   modport ctrl (
      output k_rise,
      output c_rise,
      output out_clk_tied_high,
      output read_port_select_n,
      output write_port_select_n,
      output addr,
      output wdata,
      output byte_write_select_n,
      input  rdata,
      input  rdata_oe
   );
endinterface

// >>> hdl/qbsp_lane_merge.sv
// Purpose: Byte-lane merge of a new word over a stored word
// Assumes: A low select takes the new lane
// Notes:   Pure combinational
`timescale 1ns/1ns

module qbsp_lane_merge #(
   parameter int LANE_W = 9,
   parameter int LANES  = 2
)(
   input  wire logic [LANE_W*LANES-1:0] old_word,
   input  wire logic [LANE_W*LANES-1:0] new_word,
   input  wire logic [LANES-1:0]        write_sel_n,
   output wire logic [LANE_W*LANES-1:0] merged_word
);
   // ****************************************************************
   // One multiplexer per lane
   // ****************************************************************
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : g_lane
         assign merged_word[l*LANE_W +: LANE_W] = write_sel_n[l] ?
            old_word[l*LANE_W +: LANE_W] : new_word[l*LANE_W +: LANE_W];
      end
   endgenerate
endmodule

// >>> hdl/qbsp_sram_dev.sv
// Purpose: Burst-of-four two-port SRAM, device end
// Assumes: Each input clock cycle is two clk_sys cycles, K rise first
// Notes:   Operation
// Operation
// - Write starts on low write select
// - Read returns four words over two cycles
// - Burst word n goes to bank n at the same address
// - Beats fall in the two following cycles
// - Write data sampled on both input edges
// - Single-clock mode times reads from input clock
// - Power-up: deselected, read outputs released
// - Select after a start is ignored
// - Controller never repeats an operation back-to-back
// - Second consecutive read request is ignored
// - Both selects low writes whole narrow word
// - Select 0 alone writes the low lane
// - Select 1 alone writes the high lane
// - All selects high writes nothing
// - Wide variant: four lanes of nine bits
// - Byte selects sampled on every beat
// - Stopped clocks keep state
// - Both selects from idle: read first, alternate
// - Read forwards a pending write's data
// - Output released after next positive output rise
`timescale 1ns/1ns
`include "qbsp_params.svh"

module qbsp_sram_dev #(
   parameter int WORD_W = `QBSP_WORD_W,
   parameter int LANES  = `QBSP_LANES,
   parameter int ADDR_W = `QBSP_ADDR_W
)(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   qbsp_if.dev       link,
   output logic      single_clk_mode,
   output logic      commit_pulse
);
   localparam int LANE_W = WORD_W / LANES;
   localparam int BEATS  = `QBSP_BEATS;
   localparam int DEPTH  = 1 << ADDR_W;
   localparam int CMT    = `QBSP_WR_COMMIT;

   generate
      if (LANES < 1 || LANE_W * LANES != WORD_W || ADDR_W < 1) begin : g_bad
         $error("qbsp_sram_dev: WORD_W must split evenly into LANES");
      end
   endgenerate

   // ****************************************************************
   // State
   // ****************************************************************
   logic                    strap_done_reg;
   logic                    single_reg;
   logic                    rd_prev_reg;
   logic                    wr_prev_reg;
   logic [ADDR_W-1:0]       rd_addr_reg;
   logic [ADDR_W-1:0]       wr_addr_reg;
   logic [ADDR_W-1:0]       wbuf_addr_reg;
   logic [CMT:0]            wr_sh_reg;
   logic [BEATS*WORD_W-1:0] wbuf_reg;
   logic [BEATS*LANES-1:0]  wmask_reg;
   logic [BEATS-1:0]        wval_reg;
   logic [BEATS-1:0]        wval_next;
   logic [1:0]              rd_sh_reg;
   logic                    rd_late_reg;
   logic                    q_run_reg;
   logic [1:0]              q_idx_reg;
   logic [ADDR_W-1:0]       q_addr_reg;
   logic [WORD_W-1:0]       q_reg;
   logic                    q_oe_reg;
   logic                    commit_reg;

   // ****************************************************************
   // Start decode and arbitration
   // ****************************************************************
   wire rd_req = link.k_rise & ~link.read_port_select_n & ~rd_prev_reg;
   wire wr_req = link.k_rise & ~link.write_port_select_n & ~wr_prev_reg;
   wire rd_go  = rd_req;
   wire wr_go  = wr_req & ~rd_req;
   wire commit = wr_sh_reg[CMT];
   wire out_pos = single_reg ? link.k_rise : link.c_rise;

   // ****************************************************************
   // Read beat selection and forwarding
   // ****************************************************************
   wire                    start  = (rd_sh_reg[1] | rd_late_reg) & out_pos;
   wire                    load   = start | q_run_reg;
   wire [1:0]              ld_idx = start ? 2'h0 : q_idx_reg;
   wire [ADDR_W-1:0]       ld_addr = start ? rd_addr_reg : q_addr_reg;
   wire [BEATS*WORD_W-1:0] bank_rd;
   wire [WORD_W-1:0]       ld_raw = bank_rd[int'(ld_idx)*WORD_W +: WORD_W];
   wire [WORD_W-1:0]       fwd_word;
   wire                    fwd_hit = wval_reg[ld_idx] &
                                     (wbuf_addr_reg == ld_addr);
   wire [WORD_W-1:0]       ld_word = fwd_hit ? fwd_word : ld_raw;

   qbsp_lane_merge #(
      .LANE_W (LANE_W),
      .LANES  (LANES)
   ) u_fwd (
      .old_word    (ld_raw),
      .new_word    (wbuf_reg[int'(ld_idx)*WORD_W +: WORD_W]),
      .write_sel_n (wmask_reg[int'(ld_idx)*LANES +: LANES]),
      .merged_word (fwd_word)
   );

   // ****************************************************************
   // Memory banks, one per burst position
   // ****************************************************************
   genvar b;
   generate
      for (b = 0; b < BEATS; b++) begin : g_bank
         logic [WORD_W-1:0] bank [DEPTH];
         logic [WORD_W-1:0] merged;
         assign bank_rd[b*WORD_W +: WORD_W] = bank[ld_addr];
         qbsp_lane_merge #(
            .LANE_W (LANE_W),
            .LANES  (LANES)
         ) u_merge (
            .old_word    (bank[wbuf_addr_reg]),
            .new_word    (wbuf_reg[b*WORD_W +: WORD_W]),
            .write_sel_n (wmask_reg[b*LANES +: LANES]),
            .merged_word (merged)
         );
         always_ff @(posedge clk_sys) begin
            if (commit) begin
               bank[wbuf_addr_reg] <= merged;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Strap and start tracking
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_reg <= 1'h0;
         single_reg     <= 1'h0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'h1;
         single_reg     <= link.out_clk_tied_high;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev_reg <= 1'h0;
         wr_prev_reg <= 1'h0;
      end else if (link.k_rise) begin
         rd_prev_reg <= rd_go;
         wr_prev_reg <= wr_go;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr_reg <= '0;
         wr_addr_reg <= '0;
      end else begin
         if (rd_go) begin
            rd_addr_reg <= link.addr;
         end
         if (wr_go) begin
            wr_addr_reg <= link.addr;
         end
      end
   end

   // ****************************************************************
   // Write beat capture
   // ****************************************************************
   always_comb begin
      wval_next = wval_reg;
      for (int i = 0; i < BEATS; i++) begin
         if (wr_sh_reg[i+1]) begin
            wval_next[i] = 1'h1;
         end else if (commit) begin
            wval_next[i] = 1'h0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_sh_reg     <= '0;
         wbuf_reg      <= '0;
         wmask_reg     <= '1;
         wval_reg      <= '0;
         wbuf_addr_reg <= '0;
      end else begin
         wr_sh_reg <= {wr_sh_reg[CMT-1:0], wr_go};
         wval_reg  <= wval_next;
         if (wr_sh_reg[1]) begin
            wbuf_addr_reg <= wr_addr_reg;
         end
         for (int i = 0; i < BEATS; i++) begin
            if (wr_sh_reg[i+1]) begin
               wbuf_reg[i*WORD_W +: WORD_W] <= link.wdata;
               wmask_reg[i*LANES +: LANES]  <= link.byte_write_select_n;
            end
         end
      end
   end

   // ****************************************************************
   // Read output sequencing
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_sh_reg   <= 2'h0;
         rd_late_reg <= 1'h0;
         q_run_reg   <= 1'h0;
         q_idx_reg   <= 2'h0;
         q_addr_reg  <= '0;
      end else begin
         rd_sh_reg   <= {rd_sh_reg[0], rd_go};
         rd_late_reg <= rd_sh_reg[1] & ~out_pos;
         q_run_reg   <= start | (q_run_reg & (q_idx_reg != 2'h3));
         if (start) begin
            q_idx_reg  <= 2'h1;
            q_addr_reg <= rd_addr_reg;
         end else if (q_run_reg) begin
            q_idx_reg <= q_idx_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q_reg      <= '0;
         q_oe_reg   <= 1'h0;
         commit_reg <= 1'h0;
      end else begin
         if (load) begin
            q_reg <= ld_word;
         end
         q_oe_reg   <= load | (q_oe_reg & ~out_pos);
         commit_reg <= commit;
      end
   end

   assign link.rdata      = q_reg;
   assign link.rdata_oe   = q_oe_reg;
   assign single_clk_mode = single_reg;
   assign commit_pulse    = commit_reg;
endmodule

// >>> hdl/qbsp_mem_ctrl.sv
// Purpose: Memory controller end driving the burst SRAM pins
// Assumes: Output clock pair runs with zero skew to the input pair
// Notes:   One request per positive input clock rise
`timescale 1ns/1ns
`include "qbsp_params.svh"

module qbsp_mem_ctrl #(
   parameter int WORD_W     = `QBSP_WORD_W,
   parameter int LANES      = `QBSP_LANES,
   parameter int ADDR_W     = `QBSP_ADDR_W,
   parameter bit SINGLE_CLK = 1'b0
)(
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   qbsp_if.ctrl                         link,
   input  wire logic                    usr_rd_valid,
   input  wire logic [ADDR_W-1:0]       usr_rd_addr,
   output logic                         usr_rd_ready,
   input  wire logic                    usr_wr_valid,
   input  wire logic [ADDR_W-1:0]       usr_wr_addr,
   input  wire logic [4*WORD_W-1:0]     usr_wr_data,
   input  wire logic [4*LANES-1:0]      usr_wr_sel_n,
   output logic                         usr_wr_ready,
   output logic [WORD_W-1:0]            usr_rd_data,
   output logic                         usr_rd_data_valid
);
   localparam int BEATS = `QBSP_BEATS;
   localparam int CAPLO = `QBSP_RD_CAP_LO;
   localparam int CAPHI = `QBSP_RD_CAP_HI;

   generate
      if (BEATS != 4 || LANES < 1 || WORD_W % LANES != 0) begin : g_bad
         $error("qbsp_mem_ctrl: unsupported geometry");
      end
   endgenerate

   // ****************************************************************
   // State
   // ****************************************************************
   qbsp_pkg::qbsp_op_e       last_op_reg;
   logic                     k_rise_reg;
   logic                     rd_sel_n_reg;
   logic                     wr_sel_n_reg;
   logic [ADDR_W-1:0]        addr_reg;
   logic [WORD_W-1:0]        d_reg;
   logic [LANES-1:0]         bws_n_reg;
   logic [BEATS*WORD_W-1:0]  hold_d_reg;
   logic [BEATS*LANES-1:0]   hold_m_reg;
   logic [BEATS*WORD_W-1:0]  act_d_reg;
   logic [BEATS*LANES-1:0]   act_m_reg;
   logic [BEATS:0]           wsh_reg;
   logic [CAPHI:0]           rsh_reg;
   logic                     rd_ready_reg;
   logic                     wr_ready_reg;
   logic [WORD_W-1:0]        rd_data_reg;
   logic                     rd_dv_reg;

   // ****************************************************************
   // Issue decode
   // ****************************************************************
   wire slot    = ~k_rise_reg;
   wire rd_fire = usr_rd_valid & rd_ready_reg;
   wire wr_fire = usr_wr_valid & wr_ready_reg & ~rd_fire;
   wire [1:0] beat = wsh_reg[2] ? 2'h1 : wsh_reg[3] ? 2'h2 : 2'h3;
   wire capture = |rsh_reg[CAPHI:CAPLO];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         k_rise_reg   <= 1'h0;
         rd_ready_reg <= 1'h0;
         wr_ready_reg <= 1'h0;
         last_op_reg  <= qbsp_pkg::QBSP_OP_NONE;
      end else begin
         k_rise_reg   <= ~k_rise_reg;
         rd_ready_reg <= k_rise_reg & (last_op_reg != qbsp_pkg::QBSP_OP_READ);
         wr_ready_reg <= k_rise_reg & (last_op_reg != qbsp_pkg::QBSP_OP_WRITE);
         if (slot) begin
            last_op_reg <= rd_fire ? qbsp_pkg::QBSP_OP_READ :
                           wr_fire ? qbsp_pkg::QBSP_OP_WRITE :
                                     qbsp_pkg::QBSP_OP_NONE;
         end
      end
   end

   // ****************************************************************
   // Command pins
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_sel_n_reg <= 1'h1;
         wr_sel_n_reg <= 1'h1;
         addr_reg     <= '0;
      end else begin
         rd_sel_n_reg <= ~rd_fire;
         wr_sel_n_reg <= ~wr_fire;
         if (rd_fire) begin
            addr_reg <= usr_rd_addr;
         end else if (wr_fire) begin
            addr_reg <= usr_wr_addr;
         end
      end
   end

   // ****************************************************************
   // Write beats
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wsh_reg    <= '0;
         hold_d_reg <= '0;
         hold_m_reg <= '1;
         act_d_reg  <= '0;
         act_m_reg  <= '1;
         d_reg      <= '0;
         bws_n_reg  <= '1;
      end else begin
         wsh_reg <= {wsh_reg[BEATS-1:0], wr_fire};
         if (wr_fire) begin
            hold_d_reg <= usr_wr_data;
            hold_m_reg <= usr_wr_sel_n;
         end
         if (wsh_reg[1]) begin
            act_d_reg <= hold_d_reg;
            act_m_reg <= hold_m_reg;
            d_reg     <= hold_d_reg[WORD_W-1:0];
            bws_n_reg <= hold_m_reg[LANES-1:0];
         end else if (|wsh_reg[BEATS:2]) begin
            d_reg     <= act_d_reg[int'(beat)*WORD_W +: WORD_W];
            bws_n_reg <= act_m_reg[int'(beat)*LANES +: LANES];
         end else begin
            bws_n_reg <= '1;
         end
      end
   end

   // ****************************************************************
   // Read capture
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rsh_reg     <= '0;
         rd_data_reg <= '0;
         rd_dv_reg   <= 1'h0;
      end else begin
         rsh_reg   <= {rsh_reg[CAPHI-1:0], rd_fire};
         rd_dv_reg <= capture;
         if (capture) begin
            rd_data_reg <= link.rdata;
         end
      end
   end

   assign link.k_rise              = k_rise_reg;
   assign link.c_rise              = SINGLE_CLK ? 1'h1 : k_rise_reg;
   assign link.out_clk_tied_high   = SINGLE_CLK;
   assign link.read_port_select_n  = rd_sel_n_reg;
   assign link.write_port_select_n = wr_sel_n_reg;
   assign link.addr                = addr_reg;
   assign link.wdata               = d_reg;
   assign link.byte_write_select_n = bws_n_reg;
   assign usr_rd_ready             = rd_ready_reg;
   assign usr_wr_ready             = wr_ready_reg;
   assign usr_rd_data              = rd_data_reg;
   assign usr_rd_data_valid        = rd_dv_reg;
endmodule

// >>> test/qbsp_link_sva.sv
// Purpose: Assertions on the controller to SRAM link
// Assumes: Zero skew output clock; k_rise toggles every cycle
// Notes:   Start history mirrors the every-other-rise acceptance
`timescale 1ns/1ns

module qbsp_link_sva #(
   parameter int WORD_W = 18,
   parameter int LANES  = 2,
   parameter int ADDR_W = 18
)(
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              k_rise,
   input wire logic              c_rise,
   input wire logic              out_clk_tied_high,
   input wire logic              read_port_select_n,
   input wire logic              write_port_select_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [WORD_W-1:0] wdata,
   input wire logic [LANES-1:0]  byte_write_select_n,
   input wire logic [WORD_W-1:0] rdata,
   input wire logic              rdata_oe
);
   // ****************************************************************
   // Start tracking
   // ****************************************************************
   logic [1:0] rd_hist_reg;
   wire logic  rd_req   = k_rise & ~read_port_select_n;
   wire logic  wr_req   = k_rise & ~write_port_select_n;
   wire logic  rd_start = rd_req & ~rd_hist_reg[1];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_hist_reg <= 2'h0;
      end else begin
         rd_hist_reg <= {rd_hist_reg[0], rd_start};
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_rd_start;
      rd_start;
   endsequence
   sequence s_rd_words;
      ##3 rdata_oe [*4];
   endsequence

   property p_rd_burst;
      s_rd_start |-> s_rd_words;
   endproperty
   a_rd_burst: assert property (p_rd_burst)
      else $error("read burst not driven for four cycles");

   property p_rd_release;
      s_rd_start ##2 !rd_start ##2 !rd_start |-> ##3 !rdata_oe;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("read outputs not released after last word");

   property p_oe_cause;
      $rose(rdata_oe) |-> $past(rd_start, 3);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("read outputs enabled without a start three cycles back");

   property p_oe_len;
      $fell(rdata_oe) |-> $past(rdata_oe, 4);
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read outputs enabled for fewer than four cycles");

   property p_reset_idle;
      $rose(rst_n) |-> !rdata_oe [*3];
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("read outputs driven right after reset");

   property p_rd_spacing;
      rd_req |-> ##2 !rd_req;
   endproperty
   a_rd_spacing: assert property (p_rd_spacing)
      else $error("reads requested on consecutive positive rises");

   property p_wr_spacing;
      wr_req |-> ##2 !wr_req;
   endproperty
   a_wr_spacing: assert property (p_wr_spacing)
      else $error("writes requested on consecutive positive rises");

   property p_out_clk;
      c_rise == (k_rise | out_clk_tied_high);
   endproperty
   a_out_clk: assert property (p_out_clk)
      else $error("output clock phase differs from input clock");
endmodule

// >>> test/qbsp_tb_top.sv
// Purpose: Self-checking bench for both link ends
// Assumes: Second device is driven directly in single-clock strap
// Notes:   Array model indexed by low ten address bits
`timescale 1ns/1ns

module quad_rate_burst4_sram_ports_tb_top;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        usr_rd_valid = 1'b0;
   logic [17:0] usr_rd_addr = 18'h0;
   logic        usr_wr_valid = 1'b0;
   logic [17:0] usr_wr_addr = 18'h0;
   logic [71:0] usr_wr_data = 72'h0;
   logic [7:0]  usr_wr_sel_n = 8'hFF;
   wire logic   usr_rd_ready, usr_wr_ready, usr_rd_data_valid;
   wire logic   [17:0] usr_rd_data;
   wire logic   single_a, single_b, commit_b;
   logic [17:0] mem [0:4095];
   int          n_mismatch = 0;
   int          checks_done = 0;

   qbsp_if lnk();
   qbsp_if lnk2();

   qbsp_mem_ctrl #(.SINGLE_CLK(1'b0)) qbsp_mem_ctrl_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(lnk),
      .usr_rd_valid(usr_rd_valid), .usr_rd_addr(usr_rd_addr),
      .usr_rd_ready(usr_rd_ready), .usr_wr_valid(usr_wr_valid),
      .usr_wr_addr(usr_wr_addr), .usr_wr_data(usr_wr_data),
      .usr_wr_sel_n(usr_wr_sel_n), .usr_wr_ready(usr_wr_ready),
      .usr_rd_data(usr_rd_data), .usr_rd_data_valid(usr_rd_data_valid));
   qbsp_sram_dev qbsp_sram_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(lnk), .single_clk_mode(single_a), .commit_pulse());
   qbsp_sram_dev qbsp_sram_dev_inst_b (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(lnk2), .single_clk_mode(single_b), .commit_pulse(commit_b));
   qbsp_link_sva qbsp_link_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .k_rise(lnk.k_rise), .c_rise(lnk.c_rise),
      .out_clk_tied_high(lnk.out_clk_tied_high),
      .read_port_select_n(lnk.read_port_select_n),
      .write_port_select_n(lnk.write_port_select_n),
      .addr(lnk.addr), .wdata(lnk.wdata),
      .byte_write_select_n(lnk.byte_write_select_n),
      .rdata(lnk.rdata), .rdata_oe(lnk.rdata_oe));

   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      #1;
      lnk2.k_rise = rst_n & ~lnk2.k_rise;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [71:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic do_write(input logic [17:0] a, input logic [71:0] d,
                           input logic [7:0] s);
      int n;
      @(posedge clk_sys);
      #1;
      usr_wr_addr = a;
      usr_wr_data = d;
      usr_wr_sel_n = s;
      usr_wr_valid = 1'b1;
      n = 0;
      while (usr_wr_ready !== 1'b1 && n < 40)
         @(posedge clk_sys) #1 n++;
      @(posedge clk_sys) #1 usr_wr_valid = 1'b0;
      check("write taken", n < 40, 1'b1);
      for (int k = 0; k < 8; k++)
         if (!s[k]) mem[int'(a[9:0])*4 + k/2][(k%2)*9 +: 9] = d[k*9 +: 9];
   endtask

   task automatic do_read(input logic [17:0] a);
      int n;
      int k;
      @(posedge clk_sys);
      #1;
      usr_rd_addr = a;
      usr_rd_valid = 1'b1;
      n = 0;
      while (usr_rd_ready !== 1'b1 && n < 40)
         @(posedge clk_sys) #1 n++;
      @(posedge clk_sys) #1 usr_rd_valid = 1'b0;
      k = 0;
      while (k < 4 && n < 80) begin
         @(posedge clk_sys) #1 n++;
         if (usr_rd_data_valid === 1'b1) begin
            check("read word", usr_rd_data, mem[int'(a[9:0])*4 + k]);
            k++;
         end
      end
      check("read words", k, 4);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      check("read enables", {lnk.rdata_oe, lnk2.rdata_oe}, 2'h0);
      check("strap", {single_a, single_b}, 2'h1);
      $display("t_reset done");
   endtask

   task automatic t_lanes();
      do_write(18'h00010, 72'h34_5678_9ABC_DEF0_1234, 8'h00);
      do_read(18'h00010);
      do_write(18'h00010, 72'hDC_BA98_7654_3210_FEDC, 8'h39);
      do_read(18'h00010);
      $display("t_lanes done");
   endtask

   task automatic t_forward();
      do_write(18'h00300, 72'h5A_A5A5_5A5A_A5A5_5A5A, 8'h00);
      do_write(18'h00301, 72'h33_3333_CCCC_3333_CCCC, 8'h00);
      do_read(18'h00301);
      do_write(18'h00200, 72'h0F_0F0F_F0F0_0F0F_F0F0, 8'h00);
      do_read(18'h00200);
      $display("t_forward done");
   endtask

   task automatic t_ignore();
      logic [71:0] d;
      logic        exp_oe;
      d = 72'h9A_BCDE_F012_3456_789A;
      do @(posedge clk_sys); while (lnk2.k_rise !== 1'b0);
      for (int i = 0; i < 20; i++) begin
         if (i > 0) begin @(posedge clk_sys); end
         #1;
         lnk2.write_port_select_n = !(i inside {0, 2, 10, 12});
         lnk2.read_port_select_n = !(i inside {6, 8, 10});
         lnk2.addr = 18'h00123;
         lnk2.wdata = (i >= 2 && i <= 5) ? d[(i-2)*18 +: 18] : ~lnk2.wdata;
         lnk2.byte_write_select_n = (i >= 2 && i <= 5) ? 2'h0 : 2'h3;
         exp_oe = (i >= 9 && i <= 16);
         check("alt enable", lnk2.rdata_oe, exp_oe);
         if (exp_oe) check("alt word", lnk2.rdata, d[(i-9)%4*18 +: 18]);
         check("commit", commit_b, i == 7 || i == 19);
      end
      $display("t_ignore done");
   endtask

   initial begin
      lnk2.c_rise = 1'b1;
      lnk2.out_clk_tied_high = 1'b1;
      lnk2.read_port_select_n = 1'b1;
      lnk2.write_port_select_n = 1'b1;
      lnk2.addr = 18'h0;
      lnk2.wdata = 18'h0;
      lnk2.byte_write_select_n = 2'h3;
      repeat (8) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_reset();
      t_lanes();
      t_forward();
      t_ignore();
      final_report();
   end

   initial begin
      #80000;
      n_mismatch++;
      $display("watchdog expired");
      final_report();
   end
endmodule
